// ===== verilog/cbsc_top.sv
// Configuration register bank and output logic of the clock buffer
// Function
// - One register byte per transaction; further bytes are not acknowledged.
// - Address byte is followed directly by the register offset, no command.
// - A received data byte updates its register at once, no commit.
// - Bus address is 110110 plus the address-select pin as lowest bit.
// - An open address-select pin reads as zero through a pulldown.
// - High-speed bus mode up to 3.4 Mbit/s is supported.
// - Fast-mode and standard-mode masters work on the same bus.
// - Offset 0 bits 7..4 enable outputs 4..1; outputs 1 and 4 on.
// - Offset 0 bits 3..0 set request polarity, 1 active-high, default 1.
// - Offset 1 bits 7..4 include requests in the upstream decode.
// - Offset 1 bits 3..2 pick wired-OR, wired-AND or push-pull; 1..0 reserved.
// - Two-bit field: 0x decoder drives, 10 forces low, 11 forces high.
// - All bus bytes travel most significant bit first.
// - Reset pin sets only enables 1 and 4; power-up reloads everything.
// - Internal enable counts only while its priority bit is high.
`include "cbsc_defines.svh"
module cbsc_top import cbsc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic busAddressSelect,
	input wire logic configReset_n,
	input wire logic [3:0] requestInput,
	output logic [3:0] bufferedOutputEn,
	output logic upstreamRequestOut,
	output logic upstreamRequestOe
);
	localparam logic [2:0] RST_FILTER = 3'(`CBSC_RST_FILTER_CYC);

	cbsc_core_type reg_q, reg_d;
	logic rstSync_n;
	logic [5:0] pinSync;
	logic [3:0] reqSync;
	logic addrSelSync;
	logic rstPinSync;
	logic wrTglLink;
	logic wrTglSync;
	logic [7:0] wrOffset;
	logic [7:0] wrData;
	logic wrPending;
	logic [3:0] reqActive;
	logic [3:0] prio;
	logic [3:0] intEn;
	logic decodeHit;
	logic reqLevel;

	// Power-up reset: asserts at once, releases through two flops
	cbsc_sync #(
		.WIDTH(1)
	) rstSyncInst (
		.clk(core_clk),
		.rst_n(rst_n),
		.din(1'b1),
		.dout(rstSync_n)
	);

	// Pins from outside the core clock domain
	cbsc_sync #(
		.WIDTH(6)
	) pinSyncInst (
		.clk(core_clk),
		.rst_n(rstSync_n),
		.din({configReset_n, busAddressSelect, requestInput}),
		.dout(pinSync)
	);

	// Pad pulldown makes a floating select pin arrive here as zero
	assign reqSync = pinSync[3:0];
	assign addrSelSync = pinSync[4];
	assign rstPinSync = pinSync[5];

	// Serial slave on the bus clock; the strap and config bytes are quasi-static there
	cbsc_link linkInst (
		.sclClk(sclClk),
		.linkRst_n(rstSync_n),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.addrSel(addrSelSync),
		.cfg0(reg_q.cfg0),
		.cfg1(reg_q.cfg1),
		.ctrl(reg_q.ctrl),
		.wrToggle(wrTglLink),
		.wrOffset(wrOffset),
		.wrData(wrData)
	);

	// Write events cross as a toggle; offset and data are settled by then
	cbsc_sync #(
		.WIDTH(1)
	) wrSyncInst (
		.clk(core_clk),
		.rst_n(rstSync_n),
		.din(wrTglLink),
		.dout(wrTglSync)
	);

	assign wrPending = wrTglSync != reg_q.wrSeen;

	// Request decode, register update and output generation
	always_comb begin
		reg_d = reg_q;
		reg_d.wrSeen = wrTglSync;
		prio = reg_q.ctrl[`CBSC_PRIO_MSB:`CBSC_PRIO_LSB];
		intEn = reg_q.cfg0[`CBSC_EN_MSB:`CBSC_EN_LSB];
		reqActive = reqSync ~^ reg_q.cfg0[`CBSC_POL_MSB:`CBSC_POL_LSB];
		decodeHit = |(reqActive & reg_q.cfg1[`CBSC_INC_MSB:`CBSC_INC_LSB]);
		reqLevel = decodeHit;
		if (reg_q.ctrl[`CBSC_FORCE_MSB]) begin
			reqLevel = reg_q.ctrl[`CBSC_FORCE_LSB];
		end

		// Register writes take effect on the cycle the event arrives
		if (wrPending) begin
			if (wrOffset == `CBSC_OFFS_CFG0) begin
				reg_d.cfg0 = wrData;
			end else if (wrOffset == `CBSC_OFFS_CFG1) begin
				reg_d.cfg1 = wrData & `CBSC_CFG1_WMASK;
			end else if (wrOffset == `CBSC_OFFS_CTRL) begin
				reg_d.ctrl = wrData & `CBSC_CTRL_WMASK;
			end
			// Higher offsets have no storage, so a stray write changes nothing
		end

		// Reset pin must stay low past the spike filter to count
		if (!rstPinSync) begin
			if (reg_q.rstCnt != RST_FILTER) begin
				reg_d.rstCnt = reg_q.rstCnt + 3'h1;
			end
		end else begin
			reg_d.rstCnt = 3'h0;
		end

		// Pin reset beats a write landing in the same cycle
		if (reg_q.rstCnt == RST_FILTER) begin
			reg_d.cfg0 = reg_d.cfg0 | `CBSC_PIN_RST_SET;
		end

		// Priority bit chooses internal enable or the request pin
		reg_d.outEn = (prio & intEn) | (~prio & reqActive);

		// Upstream request driver type
		if (reg_q.cfg1[`CBSC_TYPE_MSB]) begin
			reg_d.upOut = reqLevel;
			reg_d.upOe = 1'b1;
		end else if (reg_q.cfg1[`CBSC_TYPE_MSB:`CBSC_TYPE_LSB] == `CBSC_TYPE_WIRED_AND) begin
			reg_d.upOut = 1'b0;
			reg_d.upOe = ~reqLevel;
		end else begin
			reg_d.upOut = 1'b1;
			reg_d.upOe = reqLevel;
		end
	end

	// Full defaults come back only with the power-up reset
	always_ff @(posedge core_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			reg_q.cfg0 <= `CBSC_CFG0_RESET;
			reg_q.cfg1 <= `CBSC_CFG1_RESET;
			reg_q.ctrl <= `CBSC_CTRL_RESET;
			reg_q.wrSeen <= 1'b0;
			reg_q.rstCnt <= 3'h0;
			reg_q.outEn <= 4'h0;
			reg_q.upOut <= 1'b0;
			reg_q.upOe <= 1'b0;
		end else begin
			reg_q <= reg_d;
		end
	end

	assign bufferedOutputEn = reg_q.outEn;
	assign upstreamRequestOut = reg_q.upOut;
	assign upstreamRequestOe = reg_q.upOe;

	default clocking cbscClk @(posedge core_clk);
	endclocking
	default disable iff (!rstSync_n);

	wrApply_a: assert property (
		(wrPending && wrOffset == `CBSC_OFFS_CTRL)
		|=> reg_q.ctrl == ($past(wrData) & `CBSC_CTRL_WMASK))
		else $error("control write did not land");

	pinReset_a: assert property (
		(reg_q.rstCnt == RST_FILTER && !wrPending)
		|=> reg_q.cfg0[`CBSC_EN_MSB] && reg_q.cfg0[`CBSC_EN_LSB]
			&& $stable(reg_q.cfg1) && $stable(reg_q.ctrl)
			&& reg_q.cfg0[6:5] == $past(reg_q.cfg0[6:5]))
		else $error("pin reset touched the wrong bits");

	spikeReject_a: assert property (
		(rstPinSync && !wrPending) ##1 (!rstPinSync && !wrPending) [*3]
		|=> $stable(reg_q.cfg0))
		else $error("short reset spike was not filtered");

	rsvdBits_a: assert property (
		(reg_q.cfg1 & ~`CBSC_CFG1_WMASK) == 8'h00
		&& (reg_q.ctrl & ~`CBSC_CTRL_WMASK) == 8'h00)
		else $error("reserved bits hold a one");

	highOffs_a: assert property (
		(wrPending && wrOffset > `CBSC_OFFS_CTRL && reg_q.rstCnt != RST_FILTER)
		|=> $stable(reg_q.cfg0) && $stable(reg_q.cfg1) && $stable(reg_q.ctrl))
		else $error("write above the map changed a register");

	reqFollow_a: assert property (
		(!reg_q.ctrl[`CBSC_PRIO_LSB]
			&& reqSync[0] == reg_q.cfg0[`CBSC_POL_LSB])
		|=> reg_q.outEn[0])
		else $error("active request did not enable output 1");

	intEnable_a: assert property (
		(reg_q.ctrl[`CBSC_PRIO_LSB + 1] && !reg_q.cfg0[`CBSC_EN_LSB + 1])
		|=> !reg_q.outEn[1])
		else $error("disabled output 2 still running");

	forceLow_a: assert property (
		(reg_q.ctrl[`CBSC_FORCE_MSB:`CBSC_FORCE_LSB] == `CBSC_FORCE_LOW
			&& reg_q.cfg1[`CBSC_TYPE_MSB]) [*2]
		|-> reg_q.upOe && !reg_q.upOut)
		else $error("forced low request not driven low");

	wiredOr_a: assert property (
		(reg_q.cfg1[`CBSC_TYPE_MSB:`CBSC_TYPE_LSB] == `CBSC_TYPE_WIRED_OR
			&& reg_q.ctrl[`CBSC_FORCE_MSB])
		|=> reg_q.upOut && reg_q.upOe == $past(reg_q.ctrl[`CBSC_FORCE_LSB]))
		else $error("wired-OR request driven wrongly");

	decodeIdle_a: assert property (
		(!reg_q.ctrl[`CBSC_FORCE_MSB] && reg_q.cfg1[`CBSC_TYPE_MSB]
			&& (reqActive & reg_q.cfg1[`CBSC_INC_MSB:`CBSC_INC_LSB]) == 4'h0)
		|=> reg_q.upOe && !reg_q.upOut)
		else $error("request raised with no included input");
endmodule

// ===== verilog/cbsc_defines.svh
// Constants of the clock buffer serial configuration block
`ifndef CBSC_DEFINES_SVH
`define CBSC_DEFINES_SVH
`define CBSC_ADDR_UPPER 6'h36
`define CBSC_OFFS_CFG0 8'h00
`define CBSC_OFFS_CFG1 8'h01
`define CBSC_OFFS_CTRL 8'h02
`define CBSC_CFG0_RESET 8'h9f
`define CBSC_CFG1_RESET 8'hf0
`define CBSC_CTRL_RESET 8'h09
`define CBSC_CFG1_WMASK 8'hfc
`define CBSC_CTRL_WMASK 8'hcf
`define CBSC_PIN_RST_SET 8'h90
`define CBSC_EN_MSB 7
`define CBSC_EN_LSB 4
`define CBSC_POL_MSB 3
`define CBSC_POL_LSB 0
`define CBSC_INC_MSB 7
`define CBSC_INC_LSB 4
`define CBSC_TYPE_MSB 3
`define CBSC_TYPE_LSB 2
`define CBSC_PRIO_MSB 3
`define CBSC_PRIO_LSB 0
`define CBSC_FORCE_MSB 7
`define CBSC_FORCE_LSB 6
`define CBSC_TYPE_WIRED_OR 2'h0
`define CBSC_TYPE_WIRED_AND 2'h1
`define CBSC_FORCE_LOW 2'h2
`define CBSC_FORCE_HIGH 2'h3
`define CBSC_LAST_BIT 3'h7
`define CBSC_CORE_MHZ 40
`define CBSC_RST_FILTER_NS 100
`define CBSC_RST_FILTER_CYC ((`CBSC_RST_FILTER_NS * `CBSC_CORE_MHZ + 999) / 1000)
`endif

// ===== verilog/cbsc_pkg.sv
// Types of the clock buffer serial configuration block
`include "cbsc_defines.svh"
package cbsc_pkg;
	typedef enum logic [3:0] {
		LINK_IDLE = 4'h0,
		LINK_ADDR = 4'h1,
		LINK_ACK_ADDR_W = 4'h2,
		LINK_OFFS = 4'h3,
		LINK_ACK_OFFS = 4'h4,
		LINK_WDATA = 4'h5,
		LINK_ACK_WDATA = 4'h6,
		LINK_ACK_ADDR_R = 4'h7,
		LINK_RDATA = 4'h8,
		LINK_MACK = 4'h9,
		LINK_IGNORE = 4'ha
	} cbsc_link_state_type;
	typedef struct packed {
		cbsc_link_state_type state;
		logic [2:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] offset;
		logic [7:0] wrData;
		logic wrTgl;
		logic startSeen;
	} cbsc_link_type;
	typedef struct packed {
		logic sdaOut;
		logic sdaOe;
	} cbsc_drive_type;
	typedef struct packed {
		logic [7:0] cfg0;
		logic [7:0] cfg1;
		logic [7:0] ctrl;
		logic wrSeen;
		logic [2:0] rstCnt;
		logic [3:0] outEn;
		logic upOut;
		logic upOe;
	} cbsc_core_type;
endpackage

// ===== verilog/cbsc_sync.sv
// Two flip-flop level synchroniser
module cbsc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} cbsc_sync_type;
	cbsc_sync_type sync_q, sync_d;

	// First stage feeds only the second stage
	always_comb begin
		sync_d.meta = din;
		sync_d.sync = sync_q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= '0;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q.sync;
endmodule

// ===== verilog/cbsc_link.sv
// Two-wire bus slave running on the bus clock
`include "cbsc_defines.svh"
module cbsc_link import cbsc_pkg::*; (
	input wire logic sclClk,
	input wire logic linkRst_n,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addrSel,
	input wire logic [7:0] cfg0,
	input wire logic [7:0] cfg1,
	input wire logic [7:0] ctrl,
	output logic wrToggle,
	output logic [7:0] wrOffset,
	output logic [7:0] wrData
);
	cbsc_link_type state_q, state_d;
	cbsc_drive_type drive_q, drive_d;
	logic startTgl_q;
	logic startNew;
	logic [7:0] rdByte;

	// Start and repeated start: data falls while the bus clock is high
	always_ff @(negedge sdaIn or negedge linkRst_n) begin
		if (!linkRst_n) begin
			startTgl_q <= 1'b0;
		end else if (sclClk) begin
			startTgl_q <= ~startTgl_q;
		end
	end

	// The toggle settles half a bus period before the next rising edge
	assign startNew = startTgl_q != state_q.startSeen;

	// Readback; config changes only through this port and the reset pin, so it is quiet here
	always_comb begin
		rdByte = 8'h00;
		if (state_q.offset == `CBSC_OFFS_CFG0) begin
			rdByte = cfg0;
		end else if (state_q.offset == `CBSC_OFFS_CFG1) begin
			rdByte = cfg1;
		end else if (state_q.offset == `CBSC_OFFS_CTRL) begin
			rdByte = ctrl;
		end
	end

	// Byte framing on rising bus clock, so any rate the master picks works
	always_comb begin
		state_d = state_q;
		state_d.startSeen = startTgl_q;
		state_d.bitCnt = state_q.bitCnt + 3'h1;
		state_d.shift = {state_q.shift[6:0], sdaIn};
		if (startNew) begin
			state_d.state = LINK_ADDR;
			state_d.shift = {7'h00, sdaIn};
			state_d.bitCnt = 3'h1;
		end else begin
			unique case (state_q.state)
				LINK_ADDR: begin
					if (state_q.bitCnt == `CBSC_LAST_BIT) begin
						if (state_q.shift[6:0] != {`CBSC_ADDR_UPPER, addrSel}) begin
							state_d.state = LINK_IGNORE;
						end else if (sdaIn) begin
							state_d.state = LINK_ACK_ADDR_R;
						end else begin
							state_d.state = LINK_ACK_ADDR_W;
						end
					end
				end
				LINK_ACK_ADDR_W: begin
					state_d.state = LINK_OFFS;
					state_d.bitCnt = 3'h0;
				end
				LINK_OFFS: begin
					if (state_q.bitCnt == `CBSC_LAST_BIT) begin
						state_d.offset = {state_q.shift[6:0], sdaIn};
						state_d.state = LINK_ACK_OFFS;
					end
				end
				LINK_ACK_OFFS: begin
					state_d.state = LINK_WDATA;
					state_d.bitCnt = 3'h0;
				end
				LINK_WDATA: begin
					if (state_q.bitCnt == `CBSC_LAST_BIT) begin
						state_d.wrData = {state_q.shift[6:0], sdaIn};
						state_d.wrTgl = ~state_q.wrTgl;
						state_d.state = LINK_ACK_WDATA;
					end
				end
				LINK_ACK_WDATA: begin
					state_d.state = LINK_IGNORE;
				end
				LINK_ACK_ADDR_R: begin
					state_d.shift = rdByte;
					state_d.bitCnt = 3'h0;
					state_d.state = LINK_RDATA;
				end
				LINK_RDATA: begin
					state_d.shift = {state_q.shift[6:0], 1'b1};
					if (state_q.bitCnt == `CBSC_LAST_BIT) begin
						state_d.state = LINK_MACK;
					end
				end
				LINK_MACK: begin
					state_d.state = LINK_IGNORE;
				end
				LINK_IDLE, LINK_IGNORE: begin
					state_d.state = state_q.state;
				end
				default: begin
					state_d.state = LINK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sclClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Data pin changes only while the bus clock is low
	always_comb begin
		drive_d.sdaOut = 1'b0;
		drive_d.sdaOe = (state_q.state inside {LINK_ACK_ADDR_W, LINK_ACK_OFFS, LINK_ACK_WDATA, LINK_ACK_ADDR_R})
			|| (state_q.state == LINK_RDATA && !state_q.shift[7]);
	end

	always_ff @(negedge sclClk or negedge linkRst_n) begin
		if (!linkRst_n) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	assign sdaOut = drive_q.sdaOut;
	assign sdaOe = drive_q.sdaOe;
	assign wrToggle = state_q.wrTgl;
	assign wrOffset = state_q.offset;
	assign wrData = state_q.wrData;

	oneByteWr_a: assert property (@(posedge sclClk) disable iff (!linkRst_n)
		(state_q.state == LINK_ACK_WDATA && !startNew) |=> state_q.state == LINK_IGNORE)
		else $error("second data byte was not refused");
	addrMatch_a: assert property (@(posedge sclClk) disable iff (!linkRst_n)
		state_q.state == LINK_ACK_ADDR_W |-> $past(state_q.shift[6:0]) == {`CBSC_ADDR_UPPER, addrSel})
		else $error("acknowledged a foreign address");
	wrCommit_a: assert property (@(posedge sclClk) disable iff (!linkRst_n)
		(state_q.state == LINK_WDATA && state_q.bitCnt == `CBSC_LAST_BIT && !startNew)
		|=> state_q.wrTgl != $past(state_q.wrTgl))
		else $error("data byte not handed over");
endmodule

// ===== tb/cbsc_master.sv
// Two-wire bus master model that makes the link clock and drives the data line low
module cbsc_master (
	output logic sclClk,
	output logic sdaLow,
	input wire logic sdaWire
);
	timeunit 1ns;
	timeprecision 10ps;
	// Quarter of a bit period; the bench stretches it for a slow master
	real q = 3.75;
	// Clock idles high and the line is released between frames
	initial begin
		sclClk = 1'b1;
		sdaLow = 1'b0;
	end
	// Data changes only while the clock is low and is sampled in the high phase
	task automatic put_bit(input logic b, output logic seen);
		sdaLow = ~b;
		#(q) sclClk = 1'b1;
		#(q) seen = sdaWire;
		#(q) sclClk = 1'b0;
		#(q);
	endtask
	// Eight bits then the ninth, acknowledge, slot
	task automatic send_byte(input logic [7:0] v, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) put_bit(v[i], s);
		put_bit(1'b1, nack);
	endtask
	// Odd phase keeps the frames unrelated to the core clock
	task automatic start_frame();
		#1.3 sdaLow = 1'b1;
		#(q) sclClk = 1'b0;
		#(q);
	endtask
	task automatic stop_frame();
		sdaLow = 1'b1;
		#(q) sclClk = 1'b1;
		#(q) sdaLow = 1'b0;
		#(2 * q);
	endtask
	// Address, offset, one data byte; an optional extra byte probes the slave
	task automatic write_reg(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
		input bit extra, output logic [3:0] ack);
		start_frame();
		send_byte({a, 1'b0}, ack[3]);
		send_byte(off, ack[2]);
		send_byte(d, ack[1]);
		ack[0] = 1'b1;
		if (extra) send_byte(~d, ack[0]);
		stop_frame();
	endtask
	// Offset write, repeated start, one byte read, then not-acknowledge
	task automatic read_reg(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d,
		output logic [2:0] ack);
		logic s;
		start_frame();
		send_byte({a, 1'b0}, ack[2]);
		send_byte(off, ack[1]);
		sdaLow = 1'b0;
		#(q) sclClk = 1'b1;
		#(q) sdaLow = 1'b1;
		#(q) sclClk = 1'b0;
		#(q);
		send_byte({a, 1'b1}, ack[0]);
		for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
		put_bit(1'b1, s);
		stop_frame();
	endtask
endmodule

// ===== tb/clock_buffer_serial_config_bench.sv
// Self-checking bench of the clock buffer serial configuration block
module clock_buffer_serial_config_bench;
	timeunit 1ns;
	timeprecision 10ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic busAddressSelect = 1'b0;
	logic configReset_n = 1'b1;
	logic [3:0] requestInput = 4'h0;
	logic sclClk, sdaLow, sdaWire, sdaOut, sdaOe, upOut, upOe;
	logic [3:0] bufferedOutputEn;
	logic [31:0] seed = 32'd69551;
	logic [7:0] regs [0:3];
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	// Pulled-up data line: low when either party pulls it
	assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
	cbsc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaWire), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .busAddressSelect(busAddressSelect), .configReset_n(configReset_n),
		.requestInput(requestInput), .bufferedOutputEn(bufferedOutputEn), .upstreamRequestOut(upOut),
		.upstreamRequestOe(upOe));
	cbsc_master busMaster (.sclClk(sclClk), .sdaLow(sdaLow), .sdaWire(sdaWire));
	always #12.5 core_clk = ~core_clk;
	// A hang counts as a mismatch
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Power-up contents of the register model
	function automatic void reset_model();
		regs[0] = 8'h9f;
		regs[1] = 8'hf0;
		regs[2] = 8'h09;
		regs[3] = 8'h00;
	endfunction
	// Output enables, then upstream value and drive enable
	function automatic logic [5:0] expect_pins();
		logic [3:0] act;
		logic [3:0] en;
		logic lvl;
		act = ~(requestInput ^ regs[0][3:0]);
		for (int i = 0; i < 4; i++) en[i] = regs[2][i] ? regs[0][4 + i] : act[i];
		lvl = regs[2][7] ? regs[2][6] : |(act & regs[1][7:4]);
		case (regs[1][3:2])
			2'h0: return {en, 1'b1, lvl};
			2'h1: return {en, 1'b0, ~lvl};
			default: return {en, lvl, 1'b1};
		endcase
	endfunction
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Pins are looked at mid-cycle, well after synchronisers settle
	task automatic check_pins();
		repeat (6) @(negedge core_clk);
		check_byte("pins", {2'h0, expect_pins()}, {2'h0, bufferedOutputEn, upOut, upOe});
	endtask
	// Mode 1 adds a second data byte, mode 2 uses the other device address
	task automatic bus_write(input logic [7:0] off, input logic [7:0] d, input int mode);
		logic [3:0] ack;
		busMaster.write_reg({6'h36, busAddressSelect ^ (mode == 2)}, off, d, mode == 1, ack);
		check_byte("write ack", (mode == 2) ? 8'h0f : 8'h01, {4'h0, ack});
		if (mode != 2 && off < 8'h03) begin
			regs[off] = d & ((off == 8'h01) ? 8'hfc : (off == 8'h02) ? 8'hcf : 8'hff);
		end
	endtask
	task automatic bus_read(input logic [7:0] off);
		logic [7:0] d;
		logic [2:0] ack;
		busMaster.read_reg({6'h36, busAddressSelect}, off, d, ack);
		check_byte("read ack", 8'h00, {5'h0, ack});
		check_byte("read data", regs[off[1:0]], d);
	endtask
	task automatic read_all();
		for (int k = 0; k < 4; k++) bus_read(k[7:0]);
	endtask
	task automatic new_inputs(output logic [31:0] r);
		r = next_rand();
		@(posedge core_clk);
		requestInput <= r[3:0];
		busAddressSelect <= r[4];
		@(posedge core_clk);
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		logic [31:0] r;
		reset_model();
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		// Select pin driven low reads as address bit zero
		read_all();
		check_pins();
		// Every output type against every generation code
		for (int t = 0; t < 16; t++) begin
			new_inputs(r);
			bus_write(8'h00, r[15:8], 0);
			bus_write(8'h01, {r[23:20], t[1:0], r[17:16]}, 0);
			bus_write(8'h02, {t[3:2], r[29:24]}, 0);
			check_pins();
			new_inputs(r);
			check_pins();
			bus_read(8'h01);
			bus_read(8'h02);
		end
		// Random traffic, extra bytes and foreign addresses; offsets stay at 3 or below
		for (int n = 0; n < 24; n++) begin
			new_inputs(r);
			bus_write({6'h00, r[9:8]}, r[23:16], r[10] ? 1 : 0);
			bus_write({6'h00, r[12:11]}, r[31:24], 2);
			bus_read({6'h00, r[9:8]});
			check_pins();
		end
		// Slow master on the same bus
		busMaster.q = 40.0;
		bus_write(8'h00, 8'h00, 0);
		read_all();
		busMaster.q = 3.75;
		// Reset pin sets enables 1 and 4 only
		@(posedge core_clk);
		configReset_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		configReset_n <= 1'b1;
		regs[0] = regs[0] | 8'h90;
		check_pins();
		read_all();
		// Second power-up reset in mid-run reloads everything
		bus_write(8'h01, 8'h0c, 0);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		reset_model();
		repeat (6) @(posedge core_clk);
		check_pins();
		read_all();
		tally_and_finish();
	end
endmodule
